// ===== design/rssc_step_timer.sv
// Step interval timer: one tick per programmed step time
`timescale 1ns/1ps
`default_nettype none
module rssc_step_timer #(
   parameter int BASE_CYC = rssc_pkg::STEP_BASE_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   rssc_tick_if.tmr  tk
);

   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        tick_reg;
   logic        tick_next;
   logic [15:0] period;

   // ------------------------------------------------------------
   // Interval count
   // ------------------------------------------------------------
   always_comb begin
      // Fastest code is the base; each lower code doubles it
      period    = 16'(BASE_CYC) << (rssc_pkg::RATE_FASTEST - tk.rate);
      cnt_next  = 16'h0000;
      tick_next = 1'b0;
      if (tk.run) begin
         if (cnt_reg >= period - 16'h0001) begin
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_reg  <= 16'h0000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tk.tick = tick_reg;

   tick_idle_a: assert property (@(posedge core_clk)
      disable iff (!rst_n) !tk.run ##1 !tk.run |-> !tk.tick)
      else $error("step tick while timer stopped");

endmodule
`default_nettype wire

// ===== design/rssc_top.sv
// Setpoint, ramp control and linear rail registers with ramp engine
`timescale 1ns/1ps
`default_nettype none
module rssc_top #(
   parameter int STEP_BASE_CYC = rssc_pkg::STEP_BASE_CYC,
   parameter int BLANK_CYC     = rssc_pkg::BLANK_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       write_authorised,
   output logic      [7:0] reg_rdata,
   output logic      [5:0] rail_a_code,
   output logic      [5:0] rail_b_code,
   output logic            light_load_skip_a,
   output logic            light_load_skip_b,
   output logic      [5:0] buck_boost_code,
   output logic      [5:0] linear_code,
   output logic            linear_monitor_blank,
   output logic            ramp_busy
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   rssc_pkg::rssc_state_e state_reg, state_next;
   logic [7:0]  ramp_reg,  ramp_next;
   logic [7:0]  rail_a_reg, rail_a_next;
   logic [7:0]  rail_b_reg, rail_b_next;
   logic [7:0]  bb_reg,    bb_next;
   logic [7:0]  lin_reg,   lin_next;
   logic [5:0]  cur_a_reg, cur_a_next;
   logic [5:0]  cur_b_reg, cur_b_next;
   logic [17:0] blank_cnt_reg, blank_cnt_next;
   logic        blank_reg, blank_next;
   logic        busy_reg,  busy_next;
   logic [7:0]  rdata_reg, rdata_next;

   logic        wr_a;
   logic        wr_b;
   logic        wr_ramp;
   logic        wr_bb;
   logic        wr_lin;
   logic        go_write;
   logic        start;
   logic        done;
   logic [5:0]  tgt_a;
   logic [5:0]  tgt_b;
   logic [2:0]  rate;

   rssc_tick_if tk ();

   rssc_step_timer #(
      .BASE_CYC (STEP_BASE_CYC)
   ) u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tk       (tk)
   );

   // One code per step; the voltage per code sets the slew
   function automatic logic [5:0] step_toward(input logic [5:0] cur,
                                              input logic [5:0] tgt);
      if (cur < tgt) begin
         step_toward = cur + 6'h01;
      end else if (cur > tgt) begin
         step_toward = cur - 6'h01;
      end else begin
         step_toward = cur;
      end
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   assign wr_a     = reg_wr && (reg_addr == rssc_pkg::RAIL_A_OFS);
   assign wr_b     = reg_wr && (reg_addr == rssc_pkg::RAIL_B_OFS);
   assign wr_ramp  = reg_wr && (reg_addr == rssc_pkg::RAMP_CTRL_OFS);
   assign wr_bb    = reg_wr && (reg_addr == rssc_pkg::BUCK_BOOST_OFS);
   assign wr_lin   = reg_wr && (reg_addr == rssc_pkg::LINEAR_OFS);
   assign go_write = wr_ramp && reg_wdata[rssc_pkg::GO_BIT];
   assign tgt_a    = rail_a_reg[5:0];
   assign tgt_b    = rail_b_reg[5:0];
   assign rate     = ramp_reg[2:0];
   assign start    = go_write
                  || (ramp_reg[rssc_pkg::AUTO_BIT] && (wr_a || wr_b));
   assign tk.run   = (state_reg == rssc_pkg::RSSC_STEP);
   assign tk.rate  = rate;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_comb begin
      rail_a_next = rail_a_reg;
      rail_b_next = rail_b_reg;
      bb_next     = bb_reg;
      lin_next    = lin_reg;
      ramp_next   = ramp_reg;
      if (wr_a) begin
         rail_a_next = {reg_wdata[rssc_pkg::SKIP_BIT], 1'b0, reg_wdata[5:0]};
      end
      if (wr_b) begin
         rail_b_next = {reg_wdata[rssc_pkg::SKIP_BIT], 1'b0, reg_wdata[5:0]};
      end
      // Reserved codes are dropped so the rail never sees them
      if (wr_bb && write_authorised
          && (reg_wdata[5:0] <= rssc_pkg::BB_MAX_CODE)) begin
         bb_next = {reg_wdata[rssc_pkg::SKIP_BIT], 1'b0, reg_wdata[5:0]};
      end
      if (wr_lin && write_authorised) begin
         lin_next = {2'b00, reg_wdata[5:0]};
      end
      if (wr_ramp) begin
         ramp_next[rssc_pkg::AUTO_BIT] = reg_wdata[rssc_pkg::AUTO_BIT];
         ramp_next[2:0]                = reg_wdata[2:0];
      end
      // Set wins over the self-clear
      if (done) begin
         ramp_next[rssc_pkg::GO_BIT] = 1'b0;
      end
      if (go_write) begin
         ramp_next[rssc_pkg::GO_BIT] = 1'b1;
      end
      ramp_next[5:3] = 3'b000;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ramp_reg   <= rssc_pkg::RAMP_CTRL_RST;
         rail_a_reg <= rssc_pkg::RAIL_A_RST;
         rail_b_reg <= rssc_pkg::RAIL_B_RST;
         bb_reg     <= rssc_pkg::BUCK_BOOST_RST;
         lin_reg    <= rssc_pkg::LINEAR_RST;
      end else begin
         ramp_reg   <= ramp_next;
         rail_a_reg <= rail_a_next;
         rail_b_reg <= rail_b_next;
         bb_reg     <= bb_next;
         lin_reg    <= lin_next;
      end
   end

   // ------------------------------------------------------------
   // Ramp engine
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cur_a_next = cur_a_reg;
      cur_b_next = cur_b_reg;
      done       = 1'b0;
      case (state_reg)
         rssc_pkg::RSSC_IDLE: begin
            if (start) begin
               // Snap waits a cycle so a same-cycle target write lands
               if (rate == rssc_pkg::RATE_IMMEDIATE) begin
                  state_next = rssc_pkg::RSSC_SNAP;
               end else begin
                  state_next = rssc_pkg::RSSC_STEP;
               end
            end
         end
         rssc_pkg::RSSC_STEP: begin
            if (rate == rssc_pkg::RATE_IMMEDIATE) begin
               state_next = rssc_pkg::RSSC_SNAP;
            end else if (cur_a_reg == tgt_a && cur_b_reg == tgt_b) begin
               state_next = rssc_pkg::RSSC_IDLE;
               done       = 1'b1;
            end else if (tk.tick) begin
               cur_a_next = step_toward(cur_a_reg, tgt_a);
               cur_b_next = step_toward(cur_b_reg, tgt_b);
            end
         end
         rssc_pkg::RSSC_SNAP: begin
            cur_a_next = tgt_a;
            cur_b_next = tgt_b;
            state_next = rssc_pkg::RSSC_IDLE;
            done       = 1'b1;
         end
         default: begin
            state_next = rssc_pkg::RSSC_IDLE;
         end
      endcase
      busy_next = (state_next != rssc_pkg::RSSC_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= rssc_pkg::RSSC_IDLE;
         cur_a_reg <= rssc_pkg::RAIL_A_RST[5:0];
         cur_b_reg <= rssc_pkg::RAIL_B_RST[5:0];
         busy_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_a_reg <= cur_a_next;
         cur_b_reg <= cur_b_next;
         busy_reg  <= busy_next;
      end
   end

   // ------------------------------------------------------------
   // Monitor blanking and read port
   // ------------------------------------------------------------
   always_comb begin
      blank_cnt_next = blank_cnt_reg;
      if (wr_lin && write_authorised) begin
         blank_cnt_next = 18'(BLANK_CYC);
      end else if (blank_cnt_reg != 18'h00000) begin
         blank_cnt_next = blank_cnt_reg - 18'h00001;
      end
      blank_next = (blank_cnt_next != 18'h00000);
      rdata_next = rdata_reg;
      if (reg_rd) begin
         case (reg_addr)
            rssc_pkg::RAIL_A_OFS:     rdata_next = rail_a_reg;
            rssc_pkg::RAIL_B_OFS:     rdata_next = rail_b_reg;
            rssc_pkg::BUCK_BOOST_OFS: rdata_next = bb_reg;
            rssc_pkg::RAMP_CTRL_OFS:  rdata_next = ramp_reg;
            rssc_pkg::LINEAR_OFS:     rdata_next = lin_reg;
            default:                  rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         blank_cnt_reg <= 18'h00000;
         blank_reg     <= 1'b0;
         rdata_reg     <= 8'h00;
      end else begin
         blank_cnt_reg <= blank_cnt_next;
         blank_reg     <= blank_next;
         rdata_reg     <= rdata_next;
      end
   end

   assign reg_rdata            = rdata_reg;
   assign rail_a_code          = cur_a_reg;
   assign rail_b_code          = cur_b_reg;
   assign light_load_skip_a    = rail_a_reg[rssc_pkg::SKIP_BIT];
   assign light_load_skip_b    = rail_b_reg[rssc_pkg::SKIP_BIT];
   assign buck_boost_code      = bb_reg[5:0];
   assign linear_code          = lin_reg[5:0];
   assign linear_monitor_blank = blank_reg;
   assign ramp_busy            = busy_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_go_idle;
      go_write && state_reg == rssc_pkg::RSSC_IDLE;
   endsequence
   sequence s_snap_end;
      state_reg == rssc_pkg::RSSC_SNAP && !go_write;
   endsequence

   go_starts_a: assert property (s_go_idle
      and (rate != rssc_pkg::RATE_IMMEDIATE)
      |=> state_reg == rssc_pkg::RSSC_STEP ##0 ramp_reg[rssc_pkg::GO_BIT])
      else $error("trigger did not start a ramp");
   go_clear_a: assert property (s_snap_end
      |=> !ramp_reg[rssc_pkg::GO_BIT] && state_reg == rssc_pkg::RSSC_IDLE)
      else $error("trigger bit not cleared at end");
   paced_done_a: assert property (state_reg == rssc_pkg::RSSC_STEP
      && rate != rssc_pkg::RATE_IMMEDIATE && !go_write
      && cur_a_reg == tgt_a && cur_b_reg == tgt_b
      |=> !ramp_reg[rssc_pkg::GO_BIT] && !ramp_busy)
      else $error("paced ramp did not end at target");
   auto_start_a: assert property (
      ramp_reg[rssc_pkg::AUTO_BIT] && wr_a
      && state_reg == rssc_pkg::RSSC_IDLE |=> ramp_busy)
      else $error("auto apply did not start ramp");
   no_auto_a: assert property (
      !ramp_reg[rssc_pkg::AUTO_BIT] && !go_write
      && state_reg == rssc_pkg::RSSC_IDLE |=> !ramp_busy)
      else $error("ramp started without trigger");
   snap_target_a: assert property (state_reg == rssc_pkg::RSSC_SNAP
      |=> rail_a_code == $past(tgt_a) && rail_b_code == $past(tgt_b))
      else $error("immediate rate did not apply target");
   paced_hold_a: assert property (state_reg == rssc_pkg::RSSC_STEP
      && rate != rssc_pkg::RATE_IMMEDIATE && !tk.tick
      |=> $stable(rail_a_code) && $stable(rail_b_code))
      else $error("rail moved without step tick");
   bb_untouched_a: assert property (!wr_bb |=> $stable(bb_reg))
      else $error("buck boost changed without its write");
   ramp_reset_a: assert property (disable iff (1'b0)
      !rst_n |=> ramp_reg == rssc_pkg::RAMP_CTRL_RST)
      else $error("ramp register reset value wrong");
   blank_on_a: assert property (wr_lin && write_authorised
      |=> linear_monitor_blank [*8])
      else $error("linear monitor not blanked");
   unauth_a: assert property (wr_lin && !write_authorised
      |=> $stable(lin_reg))
      else $error("unauthorised linear write took");
   bb_reserved_a: assert property (
      wr_bb && reg_wdata[5:0] > rssc_pkg::BB_MAX_CODE |=> $stable(bb_reg))
      else $error("reserved buck boost code stored");

endmodule
`default_nettype wire

// ===== shared/rssc_pkg.sv
// Constants and types of the rail setpoint and slew control block
package rssc_pkg;

   // ------------------------------------------------------------
   // Register subaddresses
   // ------------------------------------------------------------
   localparam logic [7:0] RAIL_A_OFS     = 8'h10;
   localparam logic [7:0] RAIL_B_OFS     = 8'h11;
   localparam logic [7:0] BUCK_BOOST_OFS = 8'h19;
   localparam logic [7:0] RAMP_CTRL_OFS  = 8'h1a;
   localparam logic [7:0] LINEAR_OFS     = 8'h1b;

   // ------------------------------------------------------------
   // Field positions and widths
   // ------------------------------------------------------------
   localparam int GO_BIT   = 7;
   localparam int AUTO_BIT = 6;
   localparam int SKIP_BIT = 7;
   localparam int RATE_W   = 3;
   localparam int SET_W    = 6;

   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [7:0] RAMP_CTRL_RST  = 8'h06;
   localparam logic [7:0] LINEAR_RST     = 8'h1f;
   localparam logic [7:0] BUCK_BOOST_RST = 8'hb2;
   localparam logic [7:0] RAIL_A_RST     = 8'h00;
   localparam logic [7:0] RAIL_B_RST     = 8'h00;
   localparam logic [5:0] BB_MAX_CODE    = 6'h34;
   localparam logic [2:0] RATE_IMMEDIATE = 3'h7;
   localparam logic [2:0] RATE_FASTEST   = 3'h6;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_MIN_NS   = 2500;
   localparam int STEP_BASE_CYC =
      (STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_MS      = 5;
   localparam int BLANK_CYC     =
      (BLANK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      RSSC_IDLE = 2'b00,
      RSSC_STEP = 2'b01,
      RSSC_SNAP = 2'b10
   } rssc_state_e;

endpackage

// ===== shared/rssc_tick_if.sv
// Step pacing link between the control core and its step timer
`timescale 1ns/1ps
`default_nettype none
interface rssc_tick_if;
   logic       run;
   logic [2:0] rate;
   logic       tick;
   modport ctl (output run, output rate, input tick);
   modport tmr (input run, input rate, output tick);
endinterface
`default_nettype wire

// ===== testbench/rail_setpoint_slew_control_test.sv
// Self-checking bench of the rail setpoint and slew control block
`timescale 1ns/1ps
`default_nettype none
module rail_setpoint_slew_control_test;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   localparam int STEP = 2;
   localparam int BLK  = 10;
   logic       core_clk;
   logic       rst_n;
   logic       reg_wr;
   logic       reg_rd;
   logic       write_authorised;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] rv;
   logic [5:0] rail_a_code;
   logic [5:0] rail_b_code;
   logic [5:0] buck_boost_code;
   logic [5:0] linear_code;
   logic [5:0] bb_exp;
   logic [5:0] lin_exp;
   logic       light_load_skip_a;
   logic       light_load_skip_b;
   logic       linear_monitor_blank;
   logic       ramp_busy;
   int         err_total;
   int         samples_checked;
   int         cyc = 0;

   rssc_top #(.STEP_BASE_CYC(STEP), .BLANK_CYC(BLK)) dut (
      .core_clk            (core_clk),
      .rst_n               (rst_n),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .write_authorised    (write_authorised),
      .reg_rdata           (reg_rdata),
      .rail_a_code         (rail_a_code),
      .rail_b_code         (rail_b_code),
      .light_load_skip_a   (light_load_skip_a),
      .light_load_skip_b   (light_load_skip_b),
      .buck_boost_code     (buck_boost_code),
      .linear_code         (linear_code),
      .linear_monitor_blank(linear_monitor_blank),
      .ramp_busy           (ramp_busy)
   );

   rssc_host_model host (
      .core_clk        (core_clk),
      .reg_rdata       (reg_rdata),
      .reg_wr          (reg_wr),
      .reg_rd          (reg_rd),
      .reg_addr        (reg_addr),
      .reg_wdata       (reg_wdata),
      .write_authorised(write_authorised)
   );

   always #10 core_clk = ~core_clk;

   // Whole run is about 1250 cycles, ceiling leaves wide margin
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude;
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic logic one_step(input logic [5:0] x,
                                     input logic [5:0] y);
      logic [5:0] d;
      d = x - y;
      return d == 6'h00 || d == 6'h01 || d == 6'h3f;
   endfunction

   // Snap runs pass lo of zero, as a jump is legal there
   task automatic run_ramp(input logic [5:0] ta, input logic [5:0] tb,
                           input int lo, input int hi);
      int         n;
      logic [5:0] pa;
      logic [5:0] pb;
      logic       bad;
      n   = 0;
      pa  = rail_a_code;
      pb  = rail_b_code;
      bad = 1'b0;
      while (ramp_busy !== 1'b0 && n < hi + 8) begin
         @(negedge core_clk);
         n++;
         if (lo > 0 && !(one_step(rail_a_code, pa) &&
                         one_step(rail_b_code, pb))) begin
            bad = 1'b1;
         end
         pa = rail_a_code;
         pb = rail_b_code;
      end
      chk("one_step", 8'h00, {7'h0, bad});
      chk("ramp_len", 8'h00, {7'h0, (n < lo || n > hi)});
      chk("rail_a", {2'b0, ta}, {2'b0, rail_a_code});
      chk("rail_b", {2'b0, tb}, {2'b0, rail_b_code});
      chk("bb_kept", {2'b0, bb_exp}, {2'b0, buck_boost_code});
      chk("lin_kept", {2'b0, lin_exp}, {2'b0, linear_code});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      host.rd(8'h1a, rv);
      chk("ramp_ctrl", 8'h06, rv);
      host.rd(8'h1b, rv);
      chk("linear", 8'h1f, rv);
      host.rd(8'h19, rv);
      chk("buck_boost", 8'hb2, rv);
      chk("bb_code", 8'h32, {2'b0, buck_boost_code});
      chk("busy", 8'h00, {7'h0, ramp_busy});
      host.rd(8'h55, rv);
      chk("unmapped", 8'h00, rv);
   endtask

   task automatic t_regs;
      int n;
      n = 0;
      host.wr(8'h1a, 8'h3e, 1'b0);
      host.rd(8'h1a, rv);
      chk("ramp_res", 8'h06, rv);
      host.wr(8'h1b, 8'h0a, 1'b0);
      chk("blank_unauth", 8'h00, {7'h0, linear_monitor_blank});
      host.rd(8'h1b, rv);
      chk("lin_unauth", 8'h1f, rv);
      host.wr(8'h1b, 8'hc5, 1'b1);
      while (linear_monitor_blank === 1'b1 && n < BLK + 5) begin
         @(negedge core_clk);
         n++;
      end
      chk("blank_len", 8'(BLK), 8'(n));
      lin_exp = 6'h05;
      host.rd(8'h1b, rv);
      chk("lin", 8'h05, rv);
      chk("lin_code", 8'h05, {2'b0, linear_code});
      host.wr(8'h19, 8'h34, 1'b1);
      for (int c = 8'h35; c <= 8'h3f; c++) begin
         host.wr(8'h19, 8'(c), 1'b1);
      end
      host.rd(8'h19, rv);
      chk("bb_top", 8'h34, rv);
      host.wr(8'h19, 8'h24, 1'b1);
      bb_exp = 6'h24;
      host.rd(8'h19, rv);
      chk("bb_low", 8'h24, rv);
      chk("bb_out", 8'h24, {2'b0, buck_boost_code});
      host.wr(8'h10, 8'hc0, 1'b0);
      host.wr(8'h11, 8'h80, 1'b0);
      chk("skip_a", 8'h01, {7'h0, light_load_skip_a});
      chk("skip_b", 8'h01, {7'h0, light_load_skip_b});
      host.rd(8'h10, rv);
      chk("rail_a_reg", 8'h80, rv);
   endtask

   task automatic t_ramp;
      logic [5:0] ta;
      logic [5:0] tb;
      int         p;
      host.set_rails(6'h04, 6'h02);
      repeat (20) @(negedge core_clk);
      chk("no_auto", 8'h00, {2'b0, rail_a_code});
      chk("skip_a_clr", 8'h00, {7'h0, light_load_skip_a});
      chk("skip_b_clr", 8'h00, {7'h0, light_load_skip_b});
      for (int r = 0; r < 7; r++) begin
         ta = (r % 2) ? 6'h00 : 6'h04;
         tb = (r % 2) ? 6'h00 : 6'h02;
         p  = 4 * (STEP << (6 - r));
         host.set_rails(ta, tb);
         host.wr(8'h1a, 8'h80 | 8'(r), 1'b0);
         run_ramp(ta, tb, p, p + 4);
         host.rd(8'h1a, rv);
         chk("go_clear", 8'(r), rv);
      end
      host.set_rails(6'h10, 6'h20);
      host.wr(8'h1a, 8'h87, 1'b0);
      run_ramp(6'h10, 6'h20, 0, 4);
      host.rd(8'h1a, rv);
      chk("snap_go", 8'h07, rv);
   endtask

   task automatic t_auto;
      host.wr(8'h1a, 8'h46, 1'b0);
      host.set_rails(6'h12, 6'h1e);
      run_ramp(6'h12, 6'h1e, 1, 2 * STEP + 6);
   endtask

   // Reset in the middle of a slow ramp must drop it cleanly
   task automatic t_mid_reset;
      host.wr(8'h1a, 8'h00, 1'b0);
      host.set_rails(6'h08, 6'h08);
      host.wr(8'h1a, 8'h80, 1'b0);
      repeat (4) @(negedge core_clk);
      chk("busy_mid", 8'h01, {7'h0, ramp_busy});
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      chk("rst_busy", 8'h00, {7'h0, ramp_busy});
      chk("rst_rail", 8'h00, {2'b0, rail_a_code});
      chk("rst_bb", 8'h32, {2'b0, buck_boost_code});
      host.rd(8'h1a, rv);
      chk("rst_ramp", 8'h06, rv);
      host.rd(8'h11, rv);
      chk("rst_rail_b", 8'h00, rv);
   endtask

   initial begin
      core_clk        = 1'b0;
      rst_n           = 1'b0;
      err_total       = 0;
      samples_checked = 0;
      bb_exp          = 6'h32;
      lin_exp         = 6'h1f;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_ramp();
      t_auto();
      t_mid_reset();
      conclude();
   end
endmodule
`default_nettype wire

// ===== testbench/rssc_host_model.sv
// Host side model driving the register port of the block
`timescale 1ns/1ps
`default_nettype none
module rssc_host_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] reg_rdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       write_authorised
);
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   initial begin
      reg_wr           = 1'b0;
      reg_rd           = 1'b0;
      reg_addr         = 8'h00;
      reg_wdata        = 8'h00;
      write_authorised = 1'b0;
   end

   // Released lines show the inverse so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic au);
      @(negedge core_clk);
      reg_wr           = 1'b1;
      reg_addr         = a;
      reg_wdata        = d;
      write_authorised = au;
      @(negedge core_clk);
      reg_wr           = 1'b0;
      reg_addr         = ~a;
      reg_wdata        = ~d;
      write_authorised = 1'b0;
   endtask

   // Extra cycle before sampling, the read data holds until next read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask

   // Skip bit always written as zero ahead of any lowering
   task automatic set_rails(input logic [5:0] ta, input logic [5:0] tb);
      wr(8'h10, {2'b00, ta}, 1'b0);
      wr(8'h11, {2'b00, tb}, 1'b0);
   endtask
endmodule
`default_nettype wire
